/* shared/ardc_pkg.sv */
`default_nettype none
package ardc_pkg;
   localparam logic [7:0] ARDC_OFS_GENERAL  = 8'h0a;
   localparam logic [7:0] ARDC_OFS_DPEQ01   = 8'h10;
   localparam logic [7:0] ARDC_OFS_DPEQ23   = 8'h11;
   localparam logic [7:0] ARDC_OFS_AUX_LANE = 8'h13;
   localparam logic [7:0] ARDC_OFS_DOWN_EQ  = 8'h20;
   localparam logic [7:0] ARDC_OFS_UP_EQ    = 8'h21;
   localparam logic [7:0] ARDC_OFS_USB_CTL  = 8'h22;
   localparam logic [7:0] ARDC_GENERAL_MASK = 8'h17;
   localparam int ARDC_GEN_EQ_SW   = 4;
   localparam int ARDC_GEN_FLIP    = 2;
   localparam int ARDC_AUX_MON_OFF = 7;
   localparam logic [7:0] ARDC_RST_VAL = 8'h00;
   localparam logic [6:0] ARDC_ADDR_BASE = 7'h10;
   localparam logic [1:0] ARDC_LVL_LOW   = 2'h0;
   localparam logic [1:0] ARDC_LVL_FLOAT = 2'h2;
   localparam logic [1:0] ARDC_DET_8MS  = 2'h0;
   localparam logic [1:0] ARDC_DET_12MS = 2'h1;
   localparam logic [1:0] ARDC_CMP_AUTO = 2'h0;
   localparam logic [1:0] ARDC_CMP_DOWN = 2'h1;
   localparam logic [1:0] ARDC_CMP_UP   = 2'h2;
   localparam logic [1:0] ARDC_CMP_OFF  = 2'h3;
   localparam logic [1:0] ARDC_AUX_FOLLOW = 2'h0;
   localparam logic [1:0] ARDC_AUX_NORMAL = 2'h1;
   localparam logic [1:0] ARDC_AUX_FLIP   = 2'h2;
   localparam logic [1:0] ARDC_AUX_OPEN   = 2'h3;
   localparam logic [1:0] ARDC_CFG_OFF  = 2'h0;
   localparam logic [1:0] ARDC_CFG_USB  = 2'h1;
   localparam logic [1:0] ARDC_CFG_DP4  = 2'h2;
   localparam logic [1:0] ARDC_CFG_DP2  = 2'h3;
   localparam int ARDC_CLK_HZ   = 10_000_000;
   localparam int ARDC_DET8_MS  = 8;
   localparam int ARDC_DET12_MS = 12;
   localparam int ARDC_DET8_CYC  = ARDC_DET8_MS * (ARDC_CLK_HZ / 1000);
   localparam int ARDC_DET12_CYC = ARDC_DET12_MS * (ARDC_CLK_HZ / 1000);
   localparam logic [2:0] ARDC_STRAP_DLY = 3'h6;

   typedef struct packed {
      logic [3:0][3:0] dp;
      logic [1:0][3:0] down;
      logic [3:0]      up;
   } ardc_eq_s;

   typedef struct packed {
      logic [3:0] lane_en;
      logic       usb_en;
      logic [1:0] aux_route;
      logic       cmp_down;
      logic       cmp_up;
      logic       cmp_off;
      logic       serial_mode;
   } ardc_ctl_s;

   typedef enum logic [2:0] {
      ARDC_IDLE, ARDC_ADDR, ARDC_AACK, ARDC_RX, ARDC_RXACK, ARDC_TX, ARDC_TXACK, ARDC_TXNEXT
   } ardc_i2c_e;
endpackage
`default_nettype wire

/* src/ardc_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module ardc_sync
   import ardc_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         core_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] ff1_q, ff2_q, ff3_q, out_q;
   logic [W-1:0] out_d;

   // only the second and third stage are compared, so a metastable first stage never leaks
   always_comb begin
      out_d = (ff2_q == ff3_q) ? ff3_q : out_q;
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ff1_q <= '0;
         ff2_q <= '0;
         ff3_q <= '0;
         out_q <= '0;
      end else begin
         ff1_q <= async_i;
         ff2_q <= ff1_q;
         ff3_q <= ff2_q;
         out_q <= out_d;
      end
   end

   assign sync_o = out_q;
endmodule // ardc_sync
`default_nettype wire

/* src/ardc_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ardc_top
   import ardc_pkg::*;
#(
   parameter int DET8_CYC  = ARDC_DET8_CYC,
   parameter int DET12_CYC = ARDC_DET12_CYC
) (
   input  wire logic       core_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_n_o,
   input  wire logic [1:0] ctl_port_sel_lvl_i,
   input  wire logic       config_pin_high_i,
   input  wire logic       config_pin_low_i,
   input  wire logic       flip_pin_i,
   input  wire logic [1:0] display_eq_addr1_pin_i,
   input  wire logic [1:0] usb_eq_addr0_pin_i,
   input  wire logic [1:0] down_eq_pin_i,
   input  wire logic       cm_fsm_active_i,
   output ardc_eq_s        eq_o,
   output ardc_ctl_s       ctl_o,
   output logic            rx_detect_pulse_o
);
   logic       scl_s, sda_s;
   logic [10:0] pins_s;

   ardc_sync #(.W(1)) u_scl (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .async_i    (scl_i),
      .sync_o     (scl_s)
   );
   ardc_sync #(.W(1)) u_sda (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .async_i    (sda_i),
      .sync_o     (sda_s)
   );
   ardc_sync #(.W(11)) u_pins (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .async_i    ({ctl_port_sel_lvl_i, config_pin_high_i, config_pin_low_i, flip_pin_i,
                    display_eq_addr1_pin_i, usb_eq_addr0_pin_i, down_eq_pin_i}),
      .sync_o     (pins_s)
   );

   // four strap levels spread evenly over the sixteen settings
   function automatic logic [3:0] lvl2eq(input logic [1:0] lvl);
      return {lvl, lvl};
   endfunction

   // strap capture: waits for the synchronisers to settle after reset release
   logic [2:0] strap_cnt_q, strap_cnt_d;
   logic [5:0] strap_q, strap_d;
   always_comb begin
      strap_cnt_d = strap_cnt_q;
      strap_d     = strap_q;
      if (strap_cnt_q != ARDC_STRAP_DLY) begin
         strap_cnt_d = strap_cnt_q + 3'h1;
         strap_d     = pins_s[5:0];
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         strap_cnt_q <= 3'h0;
         strap_q     <= 6'h00;
      end else begin
         strap_cnt_q <= strap_cnt_d;
         strap_q     <= strap_d;
      end
   end

   // each strap contributes one address bit; both floating gives 0x12
   logic [6:0] slave_addr;
   assign slave_addr = ARDC_ADDR_BASE | {5'h00, strap_q[5], strap_q[2]};

   ardc_eq_s strap_eq;
   assign strap_eq.dp   = {4{lvl2eq(strap_q[5:4])}};
   assign strap_eq.down = {2{lvl2eq(strap_q[1:0])}};
   assign strap_eq.up   = lvl2eq(strap_q[3:2]);

   // register file
   logic [7:0]      gen_q, aux_q, usb_q;
   logic [15:0]     dpeq_q;
   logic [7:0]      down_q;
   logic [3:0]      up_q;
   logic            eq_sw;
   logic [7:0]      rd_data;
   logic [7:0]      ptr_q;
   assign eq_sw = gen_q[ARDC_GEN_EQ_SW];

   always_comb begin
      unique case (ptr_q)
         ARDC_OFS_GENERAL:  rd_data = gen_q;
         ARDC_OFS_DPEQ01:   rd_data = eq_sw ? dpeq_q[7:0] : {strap_eq.dp[1], strap_eq.dp[0]};
         ARDC_OFS_DPEQ23:   rd_data = eq_sw ? dpeq_q[15:8] : {strap_eq.dp[3], strap_eq.dp[2]};
         ARDC_OFS_AUX_LANE: rd_data = aux_q;
         ARDC_OFS_DOWN_EQ:  rd_data = eq_sw ? down_q : {strap_eq.down[1], strap_eq.down[0]};
         ARDC_OFS_UP_EQ:    rd_data = {4'h0, eq_sw ? up_q : strap_eq.up};
         ARDC_OFS_USB_CTL:  rd_data = {ctl_o.cmp_down | ctl_o.cmp_up | (~ctl_o.cmp_off & cm_fsm_active_i),
                                       usb_q[6:0]};
         default:           rd_data = 8'h00;
      endcase
   end

   // serial slave
   ardc_i2c_e  st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_d;
   logic       first_q, first_d, rw_q, rw_d, oe_n_q, oe_n_d;
   logic       scl_p_q, sda_p_q;
   logic       rise, fall, start, stop, wr_en;
   logic [7:0] wr_data;
   assign rise  = scl_s & ~scl_p_q;
   assign fall  = ~scl_s & scl_p_q;
   assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      sh_d    = sh_q;
      tx_d    = tx_q;
      ptr_d   = ptr_q;
      first_d = first_q;
      rw_d    = rw_q;
      oe_n_d  = oe_n_q;
      wr_en   = 1'b0;
      wr_data = sh_q;
      if (start) begin
         st_d   = ARDC_ADDR;
         cnt_d  = 4'h0;
         oe_n_d = 1'b1;
      end else if (stop) begin
         st_d   = ARDC_IDLE;
         oe_n_d = 1'b1;
      end else begin
         unique case (st_q)
            ARDC_IDLE: ;
            ARDC_ADDR, ARDC_RX: begin
               if (rise) begin
                  sh_d  = {sh_q[6:0], sda_s};
                  cnt_d = cnt_q + 4'h1;
               end else if (fall && cnt_q == 4'h8) begin
                  if (st_q == ARDC_ADDR) begin
                     if (sh_q[7:1] == slave_addr) begin
                        oe_n_d = 1'b0;
                        rw_d   = sh_q[0];
                        st_d   = ARDC_AACK;
                     end else begin
                        st_d = ARDC_IDLE;
                     end
                  end else begin
                     oe_n_d  = 1'b0;
                     first_d = 1'b0;
                     st_d    = ARDC_RXACK;
                     if (first_q) begin
                        ptr_d = sh_q;
                     end else begin
                        wr_en = 1'b1;
                        ptr_d = ptr_q + 8'h01;
                     end
                  end
               end
            end
            ARDC_AACK, ARDC_RXACK: begin
               if (fall) begin
                  cnt_d = 4'h0;
                  if (st_q == ARDC_AACK && rw_q) begin
                     tx_d   = rd_data;
                     oe_n_d = rd_data[7];
                     st_d   = ARDC_TX;
                  end else begin
                     oe_n_d = 1'b1;
                     st_d   = ARDC_RX;
                     if (st_q == ARDC_AACK) begin
                        first_d = 1'b1;
                     end
                  end
               end
            end
            ARDC_TX: begin
               if (rise) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (fall) begin
                  if (cnt_q == 4'h8) begin
                     oe_n_d = 1'b1;
                     ptr_d  = ptr_q + 8'h01;
                     st_d   = ARDC_TXACK;
                  end else begin
                     tx_d   = {tx_q[6:0], 1'b0};
                     oe_n_d = tx_q[6];
                  end
               end
            end
            ARDC_TXACK: begin
               // a not-acknowledge ends the read; the master follows with stop
               if (rise) begin
                  st_d = sda_s ? ARDC_IDLE : ARDC_TXNEXT;
               end
            end
            ARDC_TXNEXT: begin
               if (fall) begin
                  cnt_d  = 4'h0;
                  tx_d   = rd_data;
                  oe_n_d = rd_data[7];
                  st_d   = ARDC_TX;
               end
            end
         endcase
      end
   end

   // register writes; unmapped offsets are dropped
   logic [7:0]  gen_d, aux_d, usb_d, down_d;
   logic [15:0] dpeq_d;
   logic [3:0]  up_d;
   always_comb begin
      gen_d  = gen_q;
      aux_d  = aux_q;
      usb_d  = usb_q;
      dpeq_d = dpeq_q;
      down_d = down_q;
      up_d   = up_q;
      if (wr_en) begin
         unique case (ptr_q)
            ARDC_OFS_GENERAL:  gen_d = wr_data & ARDC_GENERAL_MASK;
            ARDC_OFS_DPEQ01:   dpeq_d[7:0] = wr_data;
            ARDC_OFS_DPEQ23:   dpeq_d[15:8] = wr_data;
            ARDC_OFS_AUX_LANE: aux_d = wr_data & 8'hbf;
            ARDC_OFS_DOWN_EQ:  down_d = wr_data;
            ARDC_OFS_UP_EQ:    up_d = wr_data[3:0];
            ARDC_OFS_USB_CTL:  usb_d = {1'b0, wr_data[6:0]};
            default: ;
         endcase
      end
   end

   // effective configuration
   logic       serial_mode, flip;
   logic [1:0] cfg;
   ardc_ctl_s  ctl_d;
   ardc_eq_s   eq_d;
   always_comb begin
      serial_mode = pins_s[10:9] != ARDC_LVL_LOW;
      cfg  = serial_mode ? gen_q[1:0] : pins_s[8:7];
      flip = serial_mode ? gen_q[ARDC_GEN_FLIP] : pins_s[6];
      ctl_d = '0;
      ctl_d.serial_mode = serial_mode;
      unique case (cfg)
         ARDC_CFG_OFF: ctl_d.lane_en = 4'h0;
         ARDC_CFG_USB: ctl_d.lane_en = 4'h0;
         ARDC_CFG_DP4: ctl_d.lane_en = 4'hf;
         ARDC_CFG_DP2: ctl_d.lane_en = 4'h3;
      endcase
      ctl_d.usb_en = cfg[0];
      // lanes leave in arrival order and polarity; any swap is the sink's job
      if (serial_mode && aux_q[ARDC_AUX_MON_OFF]) begin
         ctl_d.lane_en = ctl_d.lane_en & ~aux_q[3:0];
      end
      unique case (aux_q[5:4])
         ARDC_AUX_FOLLOW: ctl_d.aux_route = !cfg[1] ? ARDC_AUX_OPEN
                                          : (flip ? ARDC_AUX_FLIP : ARDC_AUX_NORMAL);
         ARDC_AUX_NORMAL: ctl_d.aux_route = ARDC_AUX_NORMAL;
         ARDC_AUX_FLIP:   ctl_d.aux_route = ARDC_AUX_FLIP;
         ARDC_AUX_OPEN:   ctl_d.aux_route = ARDC_AUX_OPEN;
      endcase
      ctl_d.cmp_down = usb_q[1:0] == ARDC_CMP_DOWN;
      ctl_d.cmp_up   = usb_q[1:0] == ARDC_CMP_UP;
      ctl_d.cmp_off  = usb_q[1:0] == ARDC_CMP_OFF;
      if (serial_mode && eq_sw) begin
         eq_d.dp   = dpeq_q;
         eq_d.down = down_q;
         eq_d.up   = up_q;
      end else begin
         eq_d = strap_eq;
      end
   end

   // receiver-detect interval; reserved codes fall back to the short period
   logic [19:0] det_cnt_q, det_cnt_d, det_lim;
   logic        det_pulse_d;
   always_comb begin
      det_lim = (usb_q[3:2] == ARDC_DET_12MS) ? 20'(DET12_CYC - 1) : 20'(DET8_CYC - 1);
      det_pulse_d = det_cnt_q >= det_lim;
      det_cnt_d = det_pulse_d ? 20'h00000 : det_cnt_q + 20'h00001;
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_q    <= ARDC_IDLE;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         tx_q    <= 8'h00;
         ptr_q   <= 8'h00;
         first_q <= 1'b0;
         rw_q    <= 1'b0;
         oe_n_q  <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         gen_q   <= ARDC_RST_VAL;
         aux_q   <= ARDC_RST_VAL;
         usb_q   <= ARDC_RST_VAL;
         dpeq_q  <= 16'h0000;
         down_q  <= ARDC_RST_VAL;
         up_q    <= 4'h0;
         det_cnt_q         <= 20'h00000;
         rx_detect_pulse_o <= 1'b0;
         ctl_o   <= '0;
         eq_o    <= '0;
         sda_o   <= 1'b0;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
         tx_q    <= tx_d;
         ptr_q   <= ptr_d;
         first_q <= first_d;
         rw_q    <= rw_d;
         oe_n_q  <= oe_n_d;
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
         gen_q   <= gen_d;
         aux_q   <= aux_d;
         usb_q   <= usb_d;
         dpeq_q  <= dpeq_d;
         down_q  <= down_d;
         up_q    <= up_d;
         det_cnt_q         <= det_cnt_d;
         rx_detect_pulse_o <= det_pulse_d;
         ctl_o   <= ctl_d;
         eq_o    <= eq_d;
         sda_o   <= 1'b0;
      end
   end

   assign sda_oe_n_o = oe_n_q;
endmodule // ardc_top
`default_nettype wire

/* bench/ardc_top_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module ardc_top_sva
   import ardc_pkg::*;
#(
   parameter int DET8_CYC  = 20,
   parameter int DET12_CYC = 30
) (
   input  wire logic       core_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       sda_o,
   input  wire logic       sda_oe_n_o,
   input  wire logic [1:0] ctl_port_sel_lvl_i,
   input  wire logic       config_pin_high_i,
   input  wire logic       config_pin_low_i,
   input  wire logic [1:0] down_eq_pin_i,
   input  wire ardc_eq_s   eq_o,
   input  wire ardc_ctl_s  ctl_o,
   input  wire logic       rx_detect_pulse_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   // cycles since the last detect pulse; a code change may shorten or stretch a gap, never past the long period
   logic [17:0] gap_q;
   logic [17:0] gap_d;
   always_comb begin
      gap_d = (sys_rst_i || rx_detect_pulse_o) ? 18'h0 : gap_q + 18'h1;
   end
   always_ff @(posedge core_clk_i) begin
      gap_q <= gap_d;
   end

   detect_bound_a: assert property (gap_q <= DET12_CYC)
      else $error("detect pulse overdue");
   pulse_once_a: assert property (rx_detect_pulse_o |=> !rx_detect_pulse_o [*8])
      else $error("detect pulse too long or too close");
   cmp_onehot_a: assert property ($onehot0({ctl_o.cmp_down, ctl_o.cmp_up, ctl_o.cmp_off}))
      else $error("compliance controls overlap");
   serial_sel_a: assert property ((ctl_port_sel_lvl_i != 2'h0) [*8] |-> ctl_o.serial_mode)
      else $error("serial mode not selected");
   gpio_sel_a: assert property ((ctl_port_sel_lvl_i == 2'h0) [*8] |-> !ctl_o.serial_mode)
      else $error("gpio mode not selected");
   gpio_four_a: assert property ((ctl_port_sel_lvl_i == 2'h0 && config_pin_high_i
      && !config_pin_low_i) [*8] |-> ctl_o.lane_en == 4'hf && !ctl_o.usb_en)
      else $error("gpio display mode lanes wrong");
   usb_only_a: assert property ((ctl_port_sel_lvl_i == 2'h0 && !config_pin_high_i
      && config_pin_low_i) [*8] |-> ctl_o.usb_en && ctl_o.lane_en == 4'h0)
      else $error("usb only mode wrong");
   aux_open_a: assert property ((ctl_port_sel_lvl_i == 2'h0 && !config_pin_high_i) [*8]
      |-> ctl_o.aux_route == 2'h3)
      else $error("aux path not open");
   strap_eq_a: assert property ((ctl_port_sel_lvl_i == 2'h0 && $stable(down_eq_pin_i)) [*8]
      |-> eq_o.down == {2{down_eq_pin_i, down_eq_pin_i}})
      else $error("eq does not follow strap");
   sda_drive_a: assert property (!sda_oe_n_o |-> !sda_o)
      else $error("data line driven high");

   cover property (rx_detect_pulse_o);
   cover property (ctl_o.serial_mode && ctl_o.lane_en == 4'he);
   cover property (!sda_oe_n_o);
endmodule // ardc_top_sva
`default_nettype wire

/* bench/ardc_pdc_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ardc_pdc_model (
   input  wire logic core_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_oe_n_o
);
   initial begin
      scl_o = 1'b1;
      sda_oe_n_o = 1'b1;
   end
   // ten cycles a half period keeps well clear of the slave's synchroniser lag
   task automatic hp(input int n = 10);
      repeat (n) @(posedge core_clk_i);
   endtask
   task automatic start();
      sda_oe_n_o <= 1'b1;
      hp();
      scl_o <= 1'b1;
      hp();
      sda_oe_n_o <= 1'b0;
      hp();
      scl_o <= 1'b0;
      hp(2);
   endtask
   task automatic stop();
      sda_oe_n_o <= 1'b0;
      hp();
      scl_o <= 1'b1;
      hp();
      sda_oe_n_o <= 1'b1;
      hp();
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_oe_n_o <= b[i];
         hp();
         scl_o <= 1'b1;
         hp();
         scl_o <= 1'b0;
         hp(2);
      end
      sda_oe_n_o <= 1'b1;
      hp();
      scl_o <= 1'b1;
      hp();
      ack = !sda_i;
      scl_o <= 1'b0;
      hp(2);
   endtask
   // single byte read, always closed by a nack
   task automatic rbyte(output logic [7:0] b);
      sda_oe_n_o <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         hp();
         scl_o <= 1'b1;
         hp();
         b = {b[6:0], sda_i};
         scl_o <= 1'b0;
         hp(2);
      end
      hp();
      scl_o <= 1'b1;
      hp();
      scl_o <= 1'b0;
      hp(2);
   endtask
   task automatic reg_wr(input logic [7:0] o, input logic [7:0] d, output logic ok);
      logic a0;
      logic a1;
      logic a2;
      start();
      wbyte(8'h24, a0);
      wbyte(o, a1);
      wbyte(d, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask
   task automatic reg_rd(input logic [7:0] o, output logic [7:0] d, output logic ok);
      logic a0;
      logic a1;
      logic a2;
      start();
      wbyte(8'h24, a0);
      wbyte(o, a1);
      start();
      wbyte(8'h25, a2);
      rbyte(d);
      stop();
      ok = a0 & a1 & a2;
   endtask
endmodule // ardc_pdc_model
`default_nettype wire

/* bench/test_altmode_redriver_config.sv */
`timescale 1ns/10ps
`default_nettype none
module test_altmode_redriver_config;
   import ardc_pkg::*;
   localparam int DET8_CYC  = 20;
   localparam int DET12_CYC = 30;
   logic       core_clk_i;
   logic       rst;
   logic       scl;
   logic       m_oe_n;
   logic       sda_o;
   logic       sda_oe_n;
   logic       sda_w;
   logic [1:0] sel;
   logic       hi;
   logic       lo;
   logic       flip;
   logic       fsm;
   logic [1:0] a1;
   logic [1:0] a0;
   logic [1:0] deq;
   ardc_eq_s   eq;
   ardc_ctl_s  ctl;
   logic       pulse;
   int         failures = 0;
   int         num_checks = 0;

   // open-drain line with pull-up
   assign sda_w = m_oe_n & (sda_oe_n | sda_o);

   ardc_top #(.DET8_CYC(DET8_CYC), .DET12_CYC(DET12_CYC)) i_ardc_top (
      .core_clk_i(core_clk_i), .sys_rst_i(rst), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .ctl_port_sel_lvl_i(sel),
      .config_pin_high_i(hi), .config_pin_low_i(lo), .flip_pin_i(flip),
      .display_eq_addr1_pin_i(a1), .usb_eq_addr0_pin_i(a0), .down_eq_pin_i(deq),
      .cm_fsm_active_i(fsm), .eq_o(eq), .ctl_o(ctl), .rx_detect_pulse_o(pulse));
   ardc_pdc_model i_ardc_pdc_model (
      .core_clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_n_o(m_oe_n));

   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic hp(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   task automatic do_reset();
      @(posedge core_clk_i);
      rst <= 1'b1;
      hp(4);
      rst <= 1'b0;
      hp(12);
   endtask
   task automatic wr(input logic [7:0] o, input logic [7:0] d);
      logic ok;
      i_ardc_pdc_model.reg_wr(o, d, ok);
      chk(ok, 1'b1, "write not acked");
   endtask
   task automatic rdchk(input logic [7:0] o, input logic [7:0] exp, input string what);
      logic [7:0] d;
      logic       ok;
      i_ardc_pdc_model.reg_rd(o, d, ok);
      chk({ok, d}, {1'b1, exp}, what);
   endtask
   task automatic lanes(input logic [7:0] o, input logic [7:0] d, input logic [6:0] exp);
      wr(o, d);
      chk({ctl.lane_en, ctl.usb_en, ctl.aux_route}, exp, "lane and aux routing");
   endtask
   task automatic gap(output int n);
      n = 0;
      do begin
         @(negedge core_clk_i);
         n++;
      end while (pulse !== 1'b1 && n < 300);
      if (n >= 300) begin
         failures++;
         report_and_stop();
      end
   endtask

   task automatic t_reset();
      logic ok;
      chk(ctl.serial_mode, 1'b1, "serial mode");
      i_ardc_pdc_model.start();
      i_ardc_pdc_model.wbyte(8'h26, ok);
      i_ardc_pdc_model.stop();
      chk(ok, 1'b0, "foreign address acked");
      rdchk(ARDC_OFS_AUX_LANE, 8'h00, "aux lane reset");
      rdchk(ARDC_OFS_USB_CTL, 8'h00, "usb control reset");
      wr(8'h30, 8'h5a);
      rdchk(8'h30, 8'h00, "unmapped offset");
      $display("test reset done");
   endtask
   task automatic t_eq();
      rdchk(ARDC_OFS_DOWN_EQ, 8'h55, "down eq strap readback");
      chk(eq.down, 8'h55, "down eq from strap");
      wr(ARDC_OFS_GENERAL, 8'h10);
      wr(ARDC_OFS_DOWN_EQ, 8'h66);
      wr(ARDC_OFS_UP_EQ, 8'h08);
      wr(ARDC_OFS_DPEQ23, 8'hf0);
      chk(eq.down, 8'h66, "down eq programmed");
      chk(eq.up, 4'h8, "up eq programmed");
      chk(eq.dp[3:2], 8'hf0, "display eq extremes");
      rdchk(ARDC_OFS_DOWN_EQ, 8'h66, "down eq readback");
      $display("test eq done");
   endtask
   task automatic t_lanes();
      lanes(ARDC_OFS_GENERAL, 8'h11, 7'b0000_1_11);
      lanes(ARDC_OFS_GENERAL, 8'h13, 7'b0011_1_01);
      lanes(ARDC_OFS_GENERAL, 8'h12, 7'b1111_0_01);
      lanes(ARDC_OFS_GENERAL, 8'h16, 7'b1111_0_10);
      lanes(ARDC_OFS_AUX_LANE, 8'h01, 7'b1111_0_10);
      // lane 0 disable hits pair 0 only: swap undoing is left to the sink
      lanes(ARDC_OFS_AUX_LANE, 8'h91, 7'b1110_0_01);
      lanes(ARDC_OFS_AUX_LANE, 8'ha0, 7'b1111_0_10);
      lanes(ARDC_OFS_AUX_LANE, 8'hb0, 7'b1111_0_11);
      $display("test lanes done");
   endtask
   task automatic t_cmp();
      fsm <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(ARDC_OFS_USB_CTL, 8'(c));
         chk({ctl.cmp_down, ctl.cmp_up, ctl.cmp_off}, {c == 1, c == 2, c == 3}, "decode");
         rdchk(ARDC_OFS_USB_CTL, {c != 3, 5'h00, 2'(c)}, "compliance status");
      end
      $display("test compliance done");
   endtask
   task automatic t_det();
      int n;
      wr(ARDC_OFS_USB_CTL, 8'h04);
      gap(n);
      gap(n);
      chk(16'(n), 16'(DET12_CYC), "long detect period");
      wr(ARDC_OFS_USB_CTL, 8'h00);
      gap(n);
      gap(n);
      chk(16'(n), 16'(DET8_CYC), "short detect period");
      $display("test detect done");
   endtask
   task automatic t_gpio();
      @(posedge core_clk_i);
      sel <= 2'h0;
      hi <= 1'b1;
      lo <= 1'b0;
      do_reset();
      chk(ctl.serial_mode, 1'b0, "gpio mode");
      chk({ctl.lane_en, ctl.usb_en, ctl.aux_route}, 7'b1111_0_01, "gpio display");
      flip <= 1'b1;
      hp(12);
      chk({ctl.lane_en, ctl.usb_en, ctl.aux_route}, 7'b1111_0_10, "gpio flipped aux");
      hi <= 1'b0;
      lo <= 1'b1;
      hp(12);
      chk({ctl.lane_en, ctl.usb_en, ctl.aux_route}, 7'b0000_1_11, "gpio usb only");
      chk(eq.down, 8'h55, "gpio strap eq");
      $display("test gpio done");
   endtask

   initial begin
      rst = 1'b1;
      sel = 2'h2;
      hi = 1'b0;
      lo = 1'b0;
      flip = 1'b0;
      fsm = 1'b0;
      a1 = ARDC_LVL_FLOAT;
      a0 = ARDC_LVL_FLOAT;
      deq = 2'h1;
      do_reset();
      t_reset();
      t_eq();
      t_lanes();
      t_cmp();
      t_det();
      t_gpio();
      report_and_stop();
   end
endmodule // test_altmode_redriver_config

bind ardc_top ardc_top_sva #(.DET8_CYC(DET8_CYC), .DET12_CYC(DET12_CYC)) i_ardc_top_sva (
   .core_clk_i, .sys_rst_i, .sda_o, .sda_oe_n_o, .ctl_port_sel_lvl_i, .config_pin_high_i,
   .config_pin_low_i, .down_eq_pin_i, .eq_o, .ctl_o, .rx_detect_pulse_o);
`default_nettype wire
